// *** core/kds_defs.svh ***
// Purpose: constants for the keyboard/display scanner
// Assumes: 10 MHz system clock, one clock domain
// Notes on behaviour
// - One refresh step per tick; tick is 32 times an interval count of cycles.
// - Machine cycle is 15 oscillator periods, or 30 for the slow variant.
// - One strobe enables the character and drives its key row.
// - Scan rate chosen so at least 50 full scans happen per second.
// - Debounce length is a programmable count of complete scans.
// - Strobe bit 7 is leftmost/bottom row, bit 4 top row, bit 0 rightmost.
// - Strobe pattern comes from a table indexed by character position.
// - Table holds one-hot strobe codes, inverted when CHAR_ACT_HIGH is 0, one bit per character.
// - Blank segment code is output between characters to avoid ghosting.
// - Segment bit 7 is decimal point, bits 6..0 segments g..a.
// - Segment polarity setting selects inverted segment outputs.
// - Character count and driver polarities are build-time parameters.
// - Reference build: eight characters and sixteen keys.
// - Default polarity: high level turns a character or segment on.
// - Key accepted only after seen on 4 successive scans by default.
// - Accepted key position, left-right bottom-top from 00, goes to buffer.
// - N-key lockout; a new key needs a scan with no key held; one key reported at a time.
`ifndef KDS_DEFS_SVH
`define KDS_DEFS_SVH
`define KDS_CLK_HZ 10000000
`define KDS_OSC_PER_MC 15
`define KDS_OSC_PER_MC_SLOW 30
`define KDS_TICK_MULT 32
`define KDS_INTERVAL_DEF 16
`define KDS_DEBOUNCE_DEF 4
`define KDS_CHARS 8
`define KDS_ROWS 4
`define KDS_COLS 4
`define KDS_BLANK 8'h00
`define KDS_MIN_SCAN_HZ 50
`endif

// *** core/kds_pkg.sv ***
// Purpose: types for the keyboard/display scanner
// Assumes: kds_defs.svh holds the numbers
// Notes: key report travels as one struct
package kds_pkg;
	typedef enum logic [1:0] {
		KDS_BLANK_ST = 2'b00,
		KDS_SHOW_ST = 2'b01
	} kds_state_t;
	typedef struct packed {
		logic valid;
		logic [3:0] pos;
	} kds_key_t;
endpackage

// *** core/kds_scanner.sv ***
// Purpose: multiplexed display refresh and key matrix scanner
// Assumes: inputs synchronous to clk_sys_i; matrix returns active low
// Notes: strobe table, segment store and key buffer are held here
`timescale 1ns/1ps
`include "kds_defs.svh"
module kds_scanner #(
	parameter int CHARS = `KDS_CHARS, // Character count
	parameter int ROWS = `KDS_ROWS, // Key rows, at most CHARS
	parameter int COLS = `KDS_COLS, // Return lines
	parameter bit CHAR_ACT_HIGH = 1'b1, // Strobe driver polarity
	parameter bit SEG_ACT_HIGH = 1'b1, // Segment driver polarity
	parameter bit SLOW_MC = 1'b0, // Slow machine-cycle variant
	parameter int OSC_PER_CLK = 1 // Oscillator periods per clk
) (
	input wire logic clk_sys_i, // System clock
	input wire logic rst_i, // Sync reset, high
	input wire logic [7:0] interval_i, // Tick interval count
	input wire logic [7:0] debounce_scan_count_i, // Scans to accept
	input wire logic segment_polarity_i, // 1 inverts segments
	input wire logic pat_we_i, // Pattern store write
	input wire logic [2:0] pat_addr_i, // Character index
	input wire logic [7:0] pat_data_i, // Segment pattern
	input wire logic key_ack_i, // Host took the key
	input wire logic [COLS-1:0] key_return_port_i, // Return lines
	output logic [CHARS-1:0] character_strobe_port_o, // Strobe
	output logic [7:0] segment_pattern_port_o, // Segments
	output kds_pkg::kds_key_t key_position_buffer_o, // Key report
	output logic scan_done_o // Full-scan pulse
);
	import kds_pkg::*;

	// All checks below run on the one system clock and pause in reset
	default clocking kds_cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	localparam int MC_OSC = SLOW_MC ? `KDS_OSC_PER_MC_SLOW : `KDS_OSC_PER_MC;
	// Clocks per machine cycle, at least one
	localparam int MC_CLKS = (MC_OSC / OSC_PER_CLK) < 1 ? 1 :
		(MC_OSC / OSC_PER_CLK);
	localparam int CW = $clog2(CHARS);

	// Strobe table indexed by position; bit 0 is the rightmost character
	function automatic logic [CHARS-1:0] strobe_entry(input logic [CW-1:0] p);
		logic [CHARS-1:0] v;
		v = '0;
		v[p] = 1'b1;
		return CHAR_ACT_HIGH ? v : ~v;
	endfunction

	// Drive level for a segment byte
	function automatic logic [7:0] seg_drive(input logic [7:0] s,
		input logic inv);
		return (SEG_ACT_HIGH ^ inv) ? s : ~s;
	endfunction

	logic [7:0] pat_mem [CHARS];
	logic [4:0] mc_reg, mc_next;
	logic [12:0] tick_reg, tick_next;
	logic tick;
	kds_state_t st_reg, st_next;
	logic [CW-1:0] pos_reg, pos_next;
	logic [CHARS-1:0] stb_reg, stb_next;
	logic [7:0] seg_reg, seg_next;
	logic [3:0] cand_reg, cand_next;
	logic cand_ok_reg, cand_ok_next;
	logic seen_reg, seen_next;
	logic [3:0] seenpos_reg, seenpos_next;
	logic [7:0] cnt_reg, cnt_next;
	logic locked_reg, locked_next;
	kds_key_t key_reg, key_next;
	logic done_reg, done_next;
	logic [1:0] low_cnt;
	logic [1:0] low_col;

	// Pattern store, written by host
	always_ff @(posedge clk_sys_i) begin
		if (pat_we_i && (32'(pat_addr_i) < CHARS)) begin
			pat_mem[pat_addr_i[CW-1:0]] <= pat_data_i;
		end
	end

	// Tick divider: machine cycles, then 32 x interval of them
	always_comb begin
		mc_next = mc_reg + 5'd1;
		tick_next = tick_reg;
		tick = 1'b0;
		if (mc_reg == 5'(MC_CLKS - 1)) begin
			mc_next = '0;
			tick_next = tick_reg + 13'd1;
			// Interval of zero behaves as 256, a tick every 8192 machine cycles
			if (tick_reg >= (13'(interval_i) * 13'(`KDS_TICK_MULT)) - 13'd1) begin
				tick_next = '0;
				tick = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			mc_reg <= '0;
			tick_reg <= '0;
		end else begin
			mc_reg <= mc_next;
			tick_reg <= tick_next;
		end
	end

	// Lowest pressed column in the strobed row; counts lows for lockout
	always_comb begin
		low_cnt = '0;
		low_col = '0;
		for (int c = COLS - 1; c >= 0; c--) begin
			if (!key_return_port_i[c]) begin
				low_col = 2'(COLS - 1 - c);
				low_cnt = (low_cnt == 2'd3) ? low_cnt : low_cnt + 2'd1;
			end
		end
	end

	// Refresh sequencer and key scan; blank step comes first each tick
	always_comb begin
		st_next = st_reg;
		pos_next = pos_reg;
		stb_next = stb_reg;
		seg_next = seg_reg;
		cand_next = cand_reg;
		cand_ok_next = cand_ok_reg;
		seen_next = seen_reg;
		seenpos_next = seenpos_reg;
		cnt_next = cnt_reg;
		locked_next = locked_reg;
		key_next = key_reg;
		done_next = 1'b0;
		if (key_ack_i) begin
			key_next.valid = 1'b0;
		end
		case (st_reg)
			KDS_BLANK_ST: begin
				if (tick) begin
					// Sample row before leaving it; rows use the top strobe
					// bits, so the leftmost character's strobe is the bottom row
					if (32'(pos_reg) >= CHARS - ROWS &&
						low_cnt != 2'd0) begin
						if (low_cnt == 2'd1 && !seen_next) begin
							cand_next = 4'((CHARS - 1 - 32'(pos_reg)) * COLS) +
								4'(low_col);
						end
						seen_next = 1'b1;
						cand_ok_next = cand_ok_next & (low_cnt == 2'd1) & !seen_reg;
					end
					seg_next = seg_drive(`KDS_BLANK, segment_polarity_i);
					st_next = KDS_SHOW_ST;
				end
			end
			KDS_SHOW_ST: begin
				pos_next = (pos_reg == CW'(CHARS - 1)) ? '0 : pos_reg + CW'(1);
				stb_next = strobe_entry(pos_next);
				seg_next = seg_drive(pat_mem[pos_next], segment_polarity_i);
				st_next = KDS_BLANK_ST;
				if (pos_reg == CW'(CHARS - 1)) begin
					done_next = 1'b1;
					// End of full scan: debounce one key only
					if (seen_reg && cand_ok_reg && !locked_reg) begin
						if (cand_reg != seenpos_reg || cnt_reg == 8'd0) begin
							seenpos_next = cand_reg;
							cnt_next = 8'd1;
						end else begin
							cnt_next = cnt_reg + 8'd1;
						end
						if (cnt_next >= debounce_scan_count_i) begin
							key_next.pos = cand_reg;
							key_next.valid = 1'b1;
							locked_next = 1'b1;
						end
					end else if (!seen_reg) begin
						cnt_next = '0;
						locked_next = 1'b0;
					end else if (!locked_reg) begin
						cnt_next = '0;
					end
					seen_next = 1'b0;
					cand_ok_next = 1'b1;
				end
			end
			default: st_next = KDS_BLANK_ST;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			st_reg <= KDS_BLANK_ST;
			pos_reg <= '0;
			stb_reg <= CHAR_ACT_HIGH ? '0 : '1;
			seg_reg <= SEG_ACT_HIGH ? 8'h00 : 8'hff;
			cand_reg <= '0;
			cand_ok_reg <= 1'b1;
			seen_reg <= 1'b0;
			seenpos_reg <= '0;
			cnt_reg <= '0;
			locked_reg <= 1'b0;
			key_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			pos_reg <= pos_next;
			stb_reg <= stb_next;
			seg_reg <= seg_next;
			cand_reg <= cand_next;
			cand_ok_reg <= cand_ok_next;
			seen_reg <= seen_next;
			seenpos_reg <= seenpos_next;
			cnt_reg <= cnt_next;
			locked_reg <= locked_next;
			key_reg <= key_next;
			done_reg <= done_next;
		end
	end

	assign character_strobe_port_o = stb_reg;
	assign segment_pattern_port_o = seg_reg;
	assign key_position_buffer_o = key_reg;
	assign scan_done_o = done_reg;

	// Blank precedes each new character, then the strobe moves on
	sequence blank_s;
		st_reg == KDS_BLANK_ST && tick;
	endsequence
	sequence advance_s;
		st_reg == KDS_SHOW_ST ##1 $changed(character_strobe_port_o);
	endsequence
	blank_first_a: assert property (
		blank_s |=> segment_pattern_port_o ==
			seg_drive(`KDS_BLANK, $past(segment_polarity_i)))
		else $error("blank code not shown between characters");
	show_next_a: assert property (
		blank_s |=> advance_s)
		else $error("next character not strobed after blank");
	strobe_onehot_a: assert property (
		$changed(pos_reg) |-> $onehot(CHAR_ACT_HIGH ? stb_reg : ~stb_reg))
		else $error("strobe not one-hot");
	// A finished scan leaves the rightmost character strobed
	scan_wrap_a: assert property (
		scan_done_o |-> character_strobe_port_o[0] == CHAR_ACT_HIGH)
		else $error("scan did not wrap to the rightmost character");
	flag_ack_a: assert property (
		key_ack_i && !(st_reg == KDS_SHOW_ST && pos_reg == CW'(CHARS - 1))
		|=> !key_position_buffer_o.valid)
		else $error("key flag survived acknowledge");
	key_accept_a: assert property (
		$rose(key_position_buffer_o.valid) |-> $past(cnt_next) >=
			$past(debounce_scan_count_i))
		else $error("key accepted too early");
	// Keys are reported only when a full scan ends
	valid_scan_a: assert property (
		$rose(key_position_buffer_o.valid) |-> scan_done_o)
		else $error("key reported outside a scan end");
endmodule

// *** test/kds_matrix_model.sv ***
// Purpose: key switch matrix seen by the scanner
// Assumes: one-hot active-high strobe; rows on its top bits, bit 7 bottom
// Notes: open returns sit high on their pull-ups
`timescale 1ns/1ps
module kds_matrix_model #(
	parameter int ROWS = 4, // Key rows
	parameter int COLS = 4 // Return lines
) (
	input wire logic [7:0] strobe_i, // Row strobe
	input wire logic [15:0] keys_i, // Held keys, row*COLS+col
	output logic [COLS-1:0] ret_o // Return lines
);
	// A held key in the strobed row pulls its line low
	always_comb begin
		ret_o = {COLS{1'b1}};
		for (int r = 0; r < ROWS; r++)
			for (int c = 0; c < COLS; c++)
				if (strobe_i[8 - ROWS + r] && keys_i[r*COLS+c])
					ret_o[c] = 1'b0;
	end
endmodule

// *** test/tb.sv ***
// Purpose: self-checking bench for kds_scanner
// Assumes: interval 1 gives 480 clocks per tick
// Notes: key reports are matched in order via a queue
`timescale 1ns/1ps
module tb;
	import kds_pkg::*;
	logic clk = 1'b0, rst = 1'b1, pol = 1'b0, we = 1'b0, ack = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] data = 8'h00, seg, seg_prev, strobe, strobe_prev;
	logic [15:0] keys = 16'h0000;
	logic [3:0] ret;
	logic done, v_prev = 1'b0, armed = 1'b0, started = 1'b0;
	logic pol_req = 1'b0;
	logic [7:0] deb = 8'h04;
	kds_key_t key;
	logic [7:0] pat [8];
	logic [3:0] exp_q [$];
	logic [31:0] lfsr = 32'd67841;
	int fail_count = 0, cmp_count = 0, gap = 0;
	always #50 clk = ~clk;
	kds_scanner i_kds_scanner (
		.clk_sys_i(clk), .rst_i(rst), .interval_i(8'h01),
		.debounce_scan_count_i(deb), .segment_polarity_i(pol),
		.pat_we_i(we), .pat_addr_i(addr), .pat_data_i(data),
		.key_ack_i(ack), .key_return_port_i(ret),
		.character_strobe_port_o(strobe), .segment_pattern_port_o(seg),
		.key_position_buffer_o(key), .scan_done_o(done));
	kds_matrix_model i_kds_matrix_model (
		.strobe_i(strobe), .keys_i(keys), .ret_o(ret));
	function automatic logic [31:0] step(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Hold a key and note the position the host should get
	task automatic press(input int r, input int c);
		keys[r*4+c] = 1'b1;
		exp_q.push_back(4'((3 - r) * 4 + 3 - c));
	endtask
	// Bounded wait for a report, then acknowledge it
	task automatic take();
		int n;
		n = 0;
		while (key.valid !== 1'b1 && n < 40000) begin
			@(negedge clk);
			n++;
		end
		check(16'(key.valid), 16'h0001);
		ack = 1'b1;
		@(negedge clk);
		ack = 1'b0;
		@(negedge clk);
		check(16'(key.valid), 16'h0000);
	endtask
	// New character: one-hot, after a blank, 480 clocks apart
	always @(negedge clk) begin
		gap++;
		if (armed && strobe !== strobe_prev) begin
			check(16'($onehot(strobe)), 16'h0001);
			check(16'(seg_prev), 16'({8{pol}}));
			for (int i = 0; i < 8; i++)
				if (strobe[i])
					check(16'(seg), 16'(pat[i] ^ {8{pol}}));
			if (started)
				check(16'(gap), 16'h01e0);
			started = 1'b1;
			gap = 0;
			// Flip polarity only here so a whole tick sees one value
			if (pol_req)
				pol = ~pol;
			pol_req = 1'b0;
		end
		strobe_prev = strobe;
		seg_prev = seg;
	end
	// Each fresh report is matched against the oldest note
	always @(negedge clk) begin
		if (key.valid === 1'b1 && !v_prev) begin
			if (exp_q.size() == 0)
				check(16'h0001, 16'h0000);
			else
				check(16'(key.pos), 16'(exp_q.pop_front()));
		end
		v_prev = key.valid;
	end
	// Main sequence
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		check(16'({strobe, seg}), 16'h0000);
		for (int i = 0; i < 8; i++) begin
			lfsr = step(lfsr);
			pat[i] = lfsr[7:0];
			we = 1'b1;
			addr = 3'(i);
			data = lfsr[7:0];
			@(negedge clk);
		end
		we = 1'b0;
		armed = 1'b1;
		lfsr = step(lfsr);
		press(int'(lfsr[1:0]), int'(lfsr[3:2]));
		repeat (2) @(posedge done);
		@(negedge clk);
		check(16'(key.valid), 16'h0000);
		take();
		// Release first, or the lockout check would ride on the old lock
		keys = 16'h0000;
		repeat (2) @(posedge done);
		@(negedge clk);
		pol_req = 1'b1;
		keys = 16'h0003;
		repeat (5) @(posedge done);
		@(negedge clk);
		check(16'(key.valid), 16'h0000);
		keys = 16'h0000;
		repeat (2) @(posedge done);
		@(negedge clk);
		// A shorter debounce count accepts after two full scans
		deb = 8'h02;
		press(3, 0);
		repeat (2) @(posedge done);
		@(negedge clk);
		check(16'(key.valid), 16'h0001);
		take();
		check(16'(exp_q.size()), 16'h0000);
		end_sim();
	end
	// Watchdog well past the expected run length
	initial begin
		#9500000;
		fail_count++;
		end_sim();
	end
endmodule
